/* File: rtl/rtu_slave_read_handler.sv */
////////////////////////////////////////////////////////////////////////////
// Functional notes
// (RULE1) Accept frame only if CRC remainder is zero.
// (RULE2) CRC sent low byte before high byte.
// (RULE3) Length from function code before CRC check.
// (RULE4) Variable lengths taken from the count byte.
// (RULE5) Undefined codes dropped; codes 128-255 three bytes.
// (RULE6) Master never sends reads to address zero.
// (RULE7) Output read start field is point minus one.
// (RULE8) Master keeps start plus count within table.
// (RULE9) Start and count fields arrive high byte first.
// (RULE10) Point byte count 1..256, zero encodes 256.
// (RULE11) Byte count equals data bytes before CRC.
// (RULE12) Bits packed eight per byte, ascending from bit0.
// (RULE13) First bit is point after start field.
// (RULE14) Unused high bits of last byte are zero.
// (RULE15) Input reads work like output reads.
// (RULE16) Master asks 1 to 125 registers.
// (RULE17) Register start field is register minus one.
// (RULE18) Register byte count is twice register count.
// (RULE19) Registers ascending, high byte first.
// (RULE20) Bad CRC or foreign address gets no answer.
////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`include "rtu_defines.svh"

module rtu_slave_read_handler #(
  parameter logic [16:0] OUT_PTS = 17'h00800, // Output points present
  parameter logic [16:0] IN_PTS  = 17'h00800, // Input points present
  parameter logic [16:0] REGS    = 17'h00400  // Registers present
) (
  input  wire logic                 clk_sys,      // System clock
  input  wire logic                 rst,          // Sync reset, high
  input  wire logic [7:0]           station_addr, // Own station address
  input  wire rtu_pkg::rtu_byte_s   rx,           // Received byte strobe
  input  wire logic                 rx_gap,       // Inter-frame silence
  output rtu_pkg::rtu_byte_s        tx,           // Byte to transmit
  input  wire logic                 tx_ready,     // Transmitter takes byte
  output rtu_pkg::rtu_tbl_req_s     tbl_req,      // Table read request
  input  wire rtu_pkg::rtu_tbl_rsp_s tbl_rsp,     // Table data, 1 cycle
  output logic                      frame_drop    // Frame discarded pulse
);
  import rtu_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State.

  rtu_state_e        state,  next_state;
  logic [8:0]        cnt,    next_cnt;
  logic [15:0]       rcrc,   next_rcrc;
  logic [6:0][7:0]   hdr,    next_hdr;
  logic [8:0]        elen,   next_elen;
  logic              vlen,   next_vlen;
  logic              known,  next_known;
  logic [15:0]       tcrc,   next_tcrc;
  logic [7:0]        txb,    next_txb;
  logic [1:0]        hcnt,   next_hcnt;
  logic [15:0]       left,   next_left;
  logic [8:0]        dleft,  next_dleft;
  logic [15:0]       addr,   next_addr;
  logic              pend,   next_pend;
  logic [2:0]        bitn,   next_bitn;
  logic [15:0]       sbuf,   next_sbuf;
  logic              two,    next_two;
  rtu_tbl_e          kind,   next_kind;
  logic              next_drop;

  logic [15:0]       rcrc_out;
  logic [15:0]       tcrc_out;
  rtu_len_s          lres;
  logic [7:0]        fc;
  logic [15:0]       start;
  logic [15:0]       qty;
  logic [16:0]       end_sum;
  logic [16:0]       lim;
  logic [15:0]       qty_max;
  logic              fc_read;
  logic              crc_good;
  logic              addr_good;
  logic              accept;
  logic [8:0]        nbytes;
  logic [7:0]        pbyte;

  ////////////////////////////////////////////////////////////////////////
  // Check engines: one folds received bytes, one folds sent bytes.

  rtu_crc_step u_rx_crc (
    .crc_in  (rcrc),
    .data_in (rx.data),
    .crc_out (rcrc_out)
  );

  rtu_crc_step u_tx_crc (
    .crc_in  (tcrc),
    .data_in (txb),
    .crc_out (tcrc_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // Frame length from the function code.

  function automatic rtu_len_s len_of(input logic [7:0] code);
    rtu_len_s r;
    r = '{def: 1'b1, var_len: 1'b0, len: `RTU_LEN_STD};
    if (code >= `RTU_FC_RSP_FIRST) begin
      r.len = `RTU_LEN_RSP; // see (RULE5)
    end else if (code == `RTU_FC_EXC_STAT ||
                 code == `RTU_FC_DEV_TYPE) begin
      r.len = `RTU_LEN_SHORT; // see (RULE3)
    end else if (code == `RTU_FC_FRC_MUL ||
                 code == `RTU_FC_PRE_MUL) begin
      r.var_len = 1'b1; // see (RULE4)
      r.len     = `RTU_LEN_VAR;
    end else if ((code >= `RTU_FC_RD_OUT && code <= `RTU_FC_STD_LAST) ||
                 code == `RTU_FC_SCRATCH) begin
      r.len = `RTU_LEN_STD; // see (RULE3)
    end else begin
      r.def = 1'b0; // see (RULE5)
    end
    return r;
  endfunction

  assign lres = len_of(rx.data);

  ////////////////////////////////////////////////////////////////////////
  // Request decode; fields arrive high byte first.

  assign fc      = hdr[`RTU_POS_FC];
  assign start   = {hdr[`RTU_POS_START_HI],
                    hdr[`RTU_POS_START_LO]}; // see (RULE9)
  assign qty     = {hdr[`RTU_POS_QTY_HI], hdr[`RTU_POS_QTY_LO]}; // see (RULE9)
  assign end_sum = {1'b0, start} + {1'b0, qty};
  assign fc_read = (fc == `RTU_FC_RD_OUT) || (fc == `RTU_FC_RD_IN) ||
                   (fc == `RTU_FC_RD_REG);
  assign lim     = (fc == `RTU_FC_RD_OUT) ? OUT_PTS :
                   (fc == `RTU_FC_RD_IN)  ? IN_PTS  : REGS;
  // Point reads stop at 256 data bytes so the count field can hold it.
  assign qty_max = (fc == `RTU_FC_RD_REG) ? `RTU_REG_MAX : `RTU_PTS_MAX;
  assign crc_good  = (rcrc == 16'h0000); // see (RULE1)
  // Reads are never broadcast, so address zero is never answered.
  assign addr_good = (hdr[`RTU_POS_ADDR] == station_addr) &&
                     (hdr[`RTU_POS_ADDR] != `RTU_ADDR_BCAST); // see (RULE6)
  // Out-of-range requests are silently ignored as well.
  assign accept  = crc_good && addr_good && fc_read && (qty != 16'h0000) &&
                   (qty <= qty_max) && (end_sum <= lim); // see (RULE20)
  assign nbytes  = (fc == `RTU_FC_RD_REG) ? 9'({qty[7:0], 1'b0}) :
                   9'((17'(qty) + `RTU_PTS_ROUND) >> 3); // see (RULE18)
  assign pbyte   = sbuf[7:0] | (8'(tbl_rsp.bit_val) << bitn); // see (RULE12)

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_rcrc  = rcrc;
    next_hdr   = hdr;
    next_elen  = elen;
    next_vlen  = vlen;
    next_known = known;
    next_tcrc  = tcrc;
    next_txb   = txb;
    next_hcnt  = hcnt;
    next_left  = left;
    next_dleft = dleft;
    next_addr  = addr;
    next_pend  = pend;
    next_bitn  = bitn;
    next_sbuf  = sbuf;
    next_two   = two;
    next_kind  = kind;
    next_drop  = 1'b0;
    case (state)
      ST_RECV: begin
        if (rx_gap) begin
          next_cnt   = 9'h000;
          next_rcrc  = `RTU_CRC_INIT;
          next_known = 1'b0;
        end else if (rx.valid) begin
          // Every byte, check bytes included, goes through the engine.
          next_rcrc = rcrc_out; // see (RULE1)
          next_cnt  = cnt + 9'h001;
          if (cnt < `RTU_HDR_BYTES) begin
            next_hdr[cnt[2:0]] = rx.data;
          end
          if (cnt == 9'h001) begin
            next_elen  = lres.len; // see (RULE3)
            next_vlen  = lres.var_len;
            next_known = 1'b1;
            if (!lres.def) begin
              next_state = ST_DROP; // see (RULE5)
            end
          end
          if (cnt == `RTU_CNT_IDX && vlen) begin
            next_elen = `RTU_LEN_VAR + {1'b0, rx.data}; // see (RULE4)
          end
          if (known && (next_cnt == elen + `RTU_LEN_CRC)) begin
            next_state = ST_CHECK;
          end
        end
      end
      ST_CHECK: begin
        next_cnt   = 9'h000;
        next_rcrc  = `RTU_CRC_INIT;
        next_known = 1'b0;
        if (accept) begin
          next_state = ST_HEAD;
          next_txb   = hdr[`RTU_POS_ADDR];
          next_hcnt  = 2'h0;
          next_tcrc  = `RTU_CRC_INIT;
          next_left  = qty;
          next_dleft = nbytes;
          // Table index k holds point or register k plus one.
          next_addr  = start; // see (RULE7) (RULE13) (RULE17)
          next_kind  = (fc == `RTU_FC_RD_OUT) ? TBL_OUT :
                       (fc == `RTU_FC_RD_IN)  ? TBL_IN  :
                       TBL_REG; // see (RULE15)
        end else begin
          next_state = ST_RECV;
          next_drop  = 1'b1; // see (RULE20)
        end
      end
      ST_HEAD: begin
        if (tx_ready) begin
          next_tcrc = tcrc_out;
          next_hcnt = hcnt + 2'h1;
          case (hcnt)
            2'h0: next_txb = fc;
            // 256 point bytes wrap to zero in the count field.
            2'h1: next_txb = dleft[7:0]; // see (RULE10) (RULE11)
            default: begin
              next_state = ST_FETCH;
              next_bitn  = 3'h0;
              next_sbuf  = 16'h0000; // see (RULE14)
              next_pend  = 1'b0;
            end
          endcase
        end
      end
      ST_FETCH: begin
        if (!pend) begin
          next_pend = 1'b1;
        end else begin
          next_pend = 1'b0;
          next_left = left - 16'h0001;
          next_addr = addr + 16'h0001;
          if (kind == TBL_REG) begin
            next_sbuf  = tbl_rsp.word;
            next_two   = 1'b1;
            next_txb   = tbl_rsp.word[15:8]; // see (RULE19)
            next_state = ST_DATA;
          end else begin
            next_sbuf[7:0] = pbyte; // see (RULE12)
            next_bitn      = bitn + 3'h1;
            // A short last byte leaves its high bits at zero.
            if (bitn == `RTU_BIT_LAST || left == 16'h0001) begin
              next_txb   = pbyte; // see (RULE14)
              next_state = ST_DATA;
            end
          end
        end
      end
      ST_DATA: begin
        if (tx_ready) begin
          next_tcrc  = tcrc_out;
          next_dleft = dleft - 9'h001;
          if (two) begin
            next_two = 1'b0;
            next_txb = sbuf[7:0]; // see (RULE19)
          end else if (dleft == 9'h001) begin
            next_state = ST_CRC;
            next_txb   = tcrc_out[7:0]; // see (RULE2)
            next_hcnt  = 2'h0;
          end else begin
            next_state = ST_FETCH;
            next_bitn  = 3'h0;
            next_sbuf  = 16'h0000;
          end
        end
      end
      ST_CRC: begin
        if (tx_ready) begin
          if (hcnt == 2'h0) begin
            next_hcnt = 2'h1;
            next_txb  = tcrc[15:8]; // see (RULE2)
          end else begin
            next_state = ST_RECV;
          end
        end
      end
      ST_DROP: begin
        // Without a known length the only resync point is silence.
        if (rx_gap) begin
          next_state = ST_RECV;
          next_cnt   = 9'h000;
          next_rcrc  = `RTU_CRC_INIT;
          next_known = 1'b0;
          next_drop  = 1'b1;
        end
      end
      default: begin
        next_state = ST_RECV;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state      <= ST_RECV;
      cnt        <= 9'h000;
      rcrc       <= `RTU_CRC_INIT;
      hdr        <= '0;
      elen       <= 9'h000;
      vlen       <= 1'b0;
      known      <= 1'b0;
      tcrc       <= `RTU_CRC_INIT;
      txb        <= 8'h00;
      hcnt       <= 2'h0;
      left       <= 16'h0000;
      dleft      <= 9'h000;
      addr       <= 16'h0000;
      pend       <= 1'b0;
      bitn       <= 3'h0;
      sbuf       <= 16'h0000;
      two        <= 1'b0;
      kind       <= TBL_OUT;
      frame_drop <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      rcrc       <= next_rcrc;
      hdr        <= next_hdr;
      elen       <= next_elen;
      vlen       <= next_vlen;
      known      <= next_known;
      tcrc       <= next_tcrc;
      txb        <= next_txb;
      hcnt       <= next_hcnt;
      left       <= next_left;
      dleft      <= next_dleft;
      addr       <= next_addr;
      pend       <= next_pend;
      bitn       <= next_bitn;
      sbuf       <= next_sbuf;
      two        <= next_two;
      kind       <= next_kind;
      frame_drop <= next_drop;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign tx.valid      = (state == ST_HEAD) || (state == ST_DATA) ||
                         (state == ST_CRC);
  assign tx.data       = txb;
  assign tbl_req.rd    = (state == ST_FETCH) && !pend;
  assign tbl_req.kind  = kind;
  assign tbl_req.addr  = addr;

  ////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_CRC_ZERO: assert property ( // see (RULE1)
    state == ST_CHECK && rcrc != 16'h0000 |=> state == ST_RECV && frame_drop)
    else $error("frame with nonzero remainder was answered");

  // The remainder is frozen while the check bytes go out, so the byte
  // on offer is fixed by the half that has already been taken.
  AST_CRC_LOW_FIRST: assert property ( // see (RULE2)
    state == ST_CRC |->
    tx.valid && tx.data == ((hcnt == 2'h0) ? tcrc[7:0] : tcrc[15:8]))
    else $error("check bytes not sent low byte first");

  AST_SHORT_LEN: assert property ( // see (RULE3)
    state == ST_RECV && rx.valid && !rx_gap && cnt == 9'h003 &&
    known && elen == `RTU_LEN_SHORT |=> state == ST_CHECK)
    else $error("two-byte query not closed after four bytes");

  AST_VAR_LEN: assert property ( // see (RULE4)
    state == ST_RECV && rx.valid && !rx_gap && cnt == `RTU_CNT_IDX && vlen
    |=> elen == `RTU_LEN_VAR + {1'b0, $past(rx.data)})
    else $error("variable length not taken from count byte");

  AST_UNDEF_CODE: assert property ( // see (RULE5)
    state == ST_RECV && rx.valid && !rx_gap && cnt == 9'h001 &&
    rx.data == 8'h00 |=> state == ST_DROP)
    else $error("undefined function code not dropped");

  AST_BYTE_COUNT: assert property ( // see (RULE11)
    state == ST_HEAD && hcnt == 2'h2 |-> tx.data == nbytes[7:0])
    else $error("byte count field wrong");

  AST_FIRST_ADDR: assert property ( // see (RULE13)
    state == ST_CHECK && accept |=> addr == $past(start))
    else $error("first table index is not the start field");

  AST_ADDR_STEP: assert property ( // see (RULE12)
    state == ST_FETCH && pend |=> addr == $past(addr) + 16'h0001)
    else $error("table index not ascending by one");

  AST_NO_REPLY: assert property ( // see (RULE20)
    state == ST_CHECK && !addr_good |=> !tx.valid [*3])
    else $error("foreign or broadcast frame was answered");

  COV_POINTS: cover property (
    state == ST_CHECK && accept ##1 state == ST_HEAD && kind != TBL_REG);
  COV_REGS: cover property (
    state == ST_FETCH && pend && kind == TBL_REG);
  COV_CRC_DONE: cover property (
    state == ST_CRC && tx_ready && hcnt == 2'h1);
  COV_DROP: cover property (state == ST_DROP && rx_gap);

endmodule // rtu_slave_read_handler

/* File: common/rtu_defines.svh */
`ifndef RTU_DEFINES_SVH
`define RTU_DEFINES_SVH

// Function codes that the length decoder and the read handler know.
`define RTU_FC_RD_OUT    8'h01
`define RTU_FC_RD_IN     8'h02
`define RTU_FC_RD_REG    8'h03
`define RTU_FC_EXC_STAT  8'h07
`define RTU_FC_STD_LAST  8'h08
`define RTU_FC_FRC_MUL   8'h0f
`define RTU_FC_PRE_MUL   8'h10
`define RTU_FC_DEV_TYPE  8'h11
`define RTU_FC_SCRATCH   8'h43
`define RTU_FC_RSP_FIRST 8'h80

// Frame lengths in bytes, check bytes excluded.
`define RTU_LEN_STD      9'h006
`define RTU_LEN_SHORT    9'h002
`define RTU_LEN_VAR      9'h007
`define RTU_LEN_RSP      9'h003
`define RTU_LEN_CRC      9'h002
`define RTU_CNT_IDX      9'h006
`define RTU_HDR_BYTES    9'h007

// Field positions inside the stored header.
`define RTU_POS_ADDR     3'h0
`define RTU_POS_FC       3'h1
`define RTU_POS_START_HI 3'h2
`define RTU_POS_START_LO 3'h3
`define RTU_POS_QTY_HI   3'h4
`define RTU_POS_QTY_LO   3'h5

`define RTU_ADDR_BCAST   8'h00
`define RTU_CRC_INIT     16'hffff
`define RTU_CRC_POLY     16'ha001
`define RTU_REG_MAX      16'h007d
`define RTU_PTS_MAX      16'h0800
`define RTU_PTS_ROUND    17'h00007
`define RTU_BIT_LAST     3'h7

`endif

/* File: common/rtu_pkg.sv */
package rtu_pkg;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rtu_byte_s;

  typedef enum logic [1:0] {
    TBL_OUT = 2'h0,
    TBL_IN  = 2'h1,
    TBL_REG = 2'h3
  } rtu_tbl_e;

  typedef struct packed {
    logic       rd;
    rtu_tbl_e   kind;
    logic [15:0] addr;
  } rtu_tbl_req_s;

  typedef struct packed {
    logic        bit_val;
    logic [15:0] word;
  } rtu_tbl_rsp_s;

  typedef struct packed {
    logic       def;
    logic       var_len;
    logic [8:0] len;
  } rtu_len_s;

  typedef enum logic [2:0] {
    ST_RECV  = 3'h0,
    ST_CHECK = 3'h1,
    ST_HEAD  = 3'h3,
    ST_FETCH = 3'h2,
    ST_DATA  = 3'h6,
    ST_CRC   = 3'h7,
    ST_DROP  = 3'h5
  } rtu_state_e;

endpackage

/* File: rtl/rtu_crc_step.sv */
`timescale 1ns/10ps
`include "rtu_defines.svh"

module rtu_crc_step (
  input  wire logic [15:0] crc_in,   // Remainder before this byte
  input  wire logic [7:0]  data_in,  // Byte folded in
  output logic      [15:0] crc_out   // Remainder after this byte
);

  // Reflected form: the byte enters at the low end, one bit per step.
  always_comb begin
    logic [15:0] c;
    c = crc_in ^ {8'h00, data_in};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `RTU_CRC_POLY) : (c >> 1);
    end
    crc_out = c;
  end

endmodule // rtu_crc_step

/* File: tb/rtu_master_model.sv */
`timescale 1ns/10ps
`include "rtu_defines.svh"

module rtu_master_model (
  input  wire logic               clk_sys,  // System clock
  output rtu_pkg::rtu_byte_s      rx,       // Bytes to the slave
  output logic                    rx_gap,   // Silence between frames
  input  wire rtu_pkg::rtu_byte_s tx,       // Bytes from the slave
  output logic                    tx_ready  // Transmitter takes a byte
);
  import rtu_pkg::*;

  logic [7:0] rsp[$];
  logic       slow;

  initial begin
    rx       = '0;
    rx_gap   = 1'b0;
    tx_ready = 1'b1;
    slow     = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = `RTU_CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ `RTU_CRC_POLY) : (c >> 1);
      end
    end
    return c;
  endfunction

  // Reads are never aimed at address zero by this master.
  // A set bad flag flips one bit of the high check byte.
  task automatic send(input logic [7:0] f[$], input logic bad);
    logic [15:0] c;
    c = crc16(f);
    f.push_back(c[7:0]);
    f.push_back(c[15:8] ^ {7'h00, bad});
    foreach (f[i]) begin
      @(negedge clk_sys);
      rx = '{valid: 1'b1, data: f[i]};
      @(negedge clk_sys);
      rx = '0;
    end
  endtask

  task automatic gap();
    @(negedge clk_sys);
    rx_gap = 1'b1;
    @(negedge clk_sys);
    rx_gap = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (tx.valid === 1'b1 && tx_ready === 1'b1) begin
      rsp.push_back(tx.data);
    end
  end

  // A slow line takes a byte only every other cycle.
  always @(negedge clk_sys) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule // rtu_master_model

/* File: tb/rtu_slave_read_handler_tb.sv */
`timescale 1ns/10ps
`include "rtu_defines.svh"

module rtu_slave_read_handler_tb;
  import rtu_pkg::*;

  localparam logic [7:0] STN = 8'h2c;

  logic         clk_sys = 1'b0;
  logic         rst = 1'b1;
  rtu_byte_s    rx;
  rtu_byte_s    tx;
  logic         rx_gap;
  logic         tx_ready;
  rtu_tbl_req_s tbl_req;
  rtu_tbl_rsp_s tbl_rsp = '0;
  logic         frame_drop;
  int           fails = 0;
  int           samples_checked = 0;
  int           drops = 0;

  always #2.5 clk_sys = ~clk_sys;

  rtu_slave_read_handler #(
    .OUT_PTS(17'h00800),
    .IN_PTS (17'h00020),
    .REGS   (17'h00080)
  ) dut (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .station_addr(STN),
    .rx          (rx),
    .rx_gap      (rx_gap),
    .tx          (tx),
    .tx_ready    (tx_ready),
    .tbl_req     (tbl_req),
    .tbl_rsp     (tbl_rsp),
    .frame_drop  (frame_drop)
  );

  rtu_master_model mst (
    .clk_sys (clk_sys),
    .rx      (rx),
    .rx_gap  (rx_gap),
    .tx      (tx),
    .tx_ready(tx_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Table contents differ per kind so a wrong table shows in the data.
  function automatic logic pt(input rtu_tbl_e k, input logic [15:0] a);
    return (k == TBL_OUT) ? (a[0] ^ a[2] ^ a[5]) : ~(a[1] ^ a[3]);
  endfunction

  function automatic logic [15:0] wd(input logic [15:0] a);
    return {a[7:0] ^ 8'ha5, a[15:8] + 8'h3c};
  endfunction

  always @(negedge clk_sys) begin
    if (tbl_req.rd === 1'b1) begin
      tbl_rsp <= '{bit_val: pt(tbl_req.kind, tbl_req.addr),
                   word: wd(tbl_req.addr)};
    end
  end

  always @(posedge clk_sys) begin
    if (frame_drop === 1'b1) begin
      drops <= drops + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic no_answer(input int d0);
    repeat (40) @(posedge clk_sys);
    chk(16'(mst.rsp.size()), 16'h0000);
    chk(16'(drops - d0), 16'h0001);
  endtask

  // Sends one read; when ok, rebuilds the full answer and compares it.
  task automatic query(input logic [7:0] adr, input logic [7:0] fc,
                       input logic [15:0] st, input logic [15:0] n,
                       input logic bad, input logic ok);
    logic [7:0]  q[$];
    logic [7:0]  e[$];
    logic [7:0]  by;
    logic [15:0] w;
    rtu_tbl_e    k;
    int          d0;
    int          nb;
    int          x;
    d0 = drops;
    mst.rsp.delete();
    q = '{adr, fc, st[15:8], st[7:0], n[15:8], n[7:0]};
    mst.send(q, bad);
    if (!ok) begin
      no_answer(d0);
      return;
    end
    k = (fc == `RTU_FC_RD_OUT) ? TBL_OUT : TBL_IN;
    nb = (fc == `RTU_FC_RD_REG) ? 2 * int'(n) : (int'(n) + 7) / 8;
    e = '{adr, fc, nb[7:0]};
    if (fc == `RTU_FC_RD_REG) begin
      for (int r = 0; r < int'(n); r++) begin
        w = wd(st + r[15:0]);
        e.push_back(w[15:8]);
        e.push_back(w[7:0]);
      end
    end else begin
      for (int b = 0; b < nb; b++) begin
        for (int j = 0; j < 8; j++) begin
          x = b * 8 + j;
          by[j] = (x < int'(n)) ? pt(k, st + x[15:0]) : 1'b0;
        end
        e.push_back(by);
      end
    end
    w = mst.crc16(e);
    e.push_back(w[7:0]);
    e.push_back(w[15:8]);
    for (int t = 0; t < 20000 && mst.rsp.size() < e.size(); t++) begin
      @(posedge clk_sys);
    end
    repeat (20) @(posedge clk_sys);
    chk(16'(mst.rsp.size()), 16'(e.size()));
    chk(16'(drops - d0), 16'h0000);
    if (mst.rsp.size() == e.size()) begin
      foreach (e[i]) begin
        chk({8'h00, mst.rsp[i]}, {8'h00, e[i]});
      end
      chk(mst.crc16(mst.rsp), 16'h0000);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Master keeps counts legal except where a refusal is the point.
  task automatic t_points();
    query(STN, 8'h01, 16'h0000, 16'h0001, 1'b0, 1'b1);
    query(STN, 8'h01, 16'h0005, 16'h000d, 1'b0, 1'b1);
    mst.slow = 1'b1;
    query(STN, 8'h02, 16'h0010, 16'h0010, 1'b0, 1'b1);
    mst.slow = 1'b0;
    query(STN, 8'h01, 16'h0000, 16'h0800, 1'b0, 1'b1);
    query(STN, 8'h02, 16'h0011, 16'h0010, 1'b0, 1'b0);
    query(STN, 8'h01, 16'h0000, 16'h0000, 1'b0, 1'b0);
  endtask

  task automatic t_regs();
    query(STN, 8'h03, 16'h0003, 16'h007d, 1'b0, 1'b1);
    query(STN, 8'h03, 16'h0000, 16'h0001, 1'b0, 1'b1);
    query(STN, 8'h03, 16'h0004, 16'h007d, 1'b0, 1'b0);
    query(STN, 8'h03, 16'h0000, 16'h007e, 1'b0, 1'b0);
  endtask

  task automatic t_discard();
    query(STN, 8'h03, 16'h0000, 16'h0001, 1'b1, 1'b0);
    query(8'h2d, 8'h01, 16'h0000, 16'h0008, 1'b0, 1'b0);
  endtask

  // Every other defined code must be framed at its exact length: the good read
  // that follows each one is only parsed if the count was right.
  task automatic t_lengths();
    logic [7:0] codes[15] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0f,
                              8'h10, 8'h11, 8'h43, 8'h80, 8'hff, 8'h00,
                              8'h09, 8'h12, 8'h44};
    int         lens[15] = '{6, 6, 6, 2, 6, 9, 9, 2, 6, 3, 3, 6, 6, 6, 6};
    logic [7:0] f[$];
    int         d0;
    foreach (codes[c]) begin
      d0 = drops;
      mst.rsp.delete();
      f = '{STN, codes[c]};
      for (int i = 2; i < lens[c]; i++) begin
        f.push_back((i == 6) ? 8'h02 : 8'(i));
      end
      mst.send(f, 1'b0);
      if (c >= 11) begin
        mst.gap();
      end
      no_answer(d0);
      query(STN, 8'h03, 16'h0001, 16'h0002, 1'b0, 1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("Compared %0d values, %0d mismatches", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // About ten times the expected run length.
  initial begin
    #400000;
    fails++;
    wrap_up();
  end

  initial begin
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    t_points();
    t_regs();
    t_discard();
    t_lengths();
    wrap_up();
  end
endmodule // rtu_slave_read_handler_tb
